// ===== design/tgc_general_config.sv
// General configuration bank: AXI4-Lite slave and decoded control outputs
//
// Function
// - Drop received packets with bad IP checksum when drop bit set.
// - Trailer length field 0 to 12; zero means no trailer.
// - Clock recovery enable bit low holds recovery in power saving.
// - With cross-connect bundles, serve receive FIFO first above the programmed threshold (reset 0x100).
// - MAC select: 00 MII, 01 RMII, 11 SSMII, 10 reserved.
// - High speed bit enables only port 1; otherwise all ports active.
// - Maintenance tick every 1 us, or 100 us when select set.
// - Size bit selects 64 Mb or 128 Mb memory.
// - DRAM clock select: 00 50 MHz, 01 75 MHz, others reserved.
// - Column width code gives 8 to 11 column address bits.
// - CAS latency codes 01..11 give 1..3; resets to 2.
// - DRAM controller held in reset while its low-active bit is 0.
// - Configuration bank sits at base offset zero.
`default_nettype none
`include "tgc_regs.svh"
module tgc_general_config #(
   parameter int NUM_PORTS = 8,
   parameter int LVL_W = 10,
   parameter int FINE_CYCLES = `TGC_TICK_FINE_CYC,
   parameter int COARSE_CYCLES = `TGC_TICK_COARSE_CYC
) (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Register bus
   input wire tgc_pkg::tgc_axil_req_t axiReq,
   output tgc_pkg::tgc_axil_rsp_t axiRsp,
   // Packet checksum filter
   input wire logic rxPktValid,
   input wire logic rxPktSumBad,
   output logic rxPktDrop_q,
   // Queue arbitration
   input wire logic xcBundlesPresent,
   input wire logic [LVL_W-1:0] rxFifoLevel,
   output logic rxFifoFirst_q,
   // Packet framing and MAC
   output logic [3:0] trailerLen_q,
   output logic trailerPresent_q,
   output tgc_pkg::tgc_mac_mode_t macMode_q,
   // Ports and clock recovery
   output logic clkRecEnable_q,
   output logic highSpeedMode_q,
   output logic [NUM_PORTS-1:0] portEnable_q,
   output logic maintenanceTick_q,
   // DRAM controller setup
   output logic dramSize128_q,
   output logic [1:0] dramClockSelect_q,
   output logic [3:0] dramColBits_q,
   output logic [1:0] dramCasLatency_q,
   output logic dramRstN_q,
   // Second configuration word, raw
   output logic [31:0] generalConfigOne_q
);
   localparam logic [NUM_PORTS-1:0] PORT1_ONLY = NUM_PORTS'(1);

   tgc_pkg::tgc_cfg0_t cfg0_q;
   logic [31:0] cfg1_q;

   // Bus state
   logic awready_q, wready_q, awHeld_q, wHeld_q;
   logic [31:0] awAddr_q, wData_q;
   logic [3:0] wStrb_q;
   logic bvalid_q, arready_q, rvalid_q;
   tgc_pkg::tgc_resp_t bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic wrFire, arFire, wrHit0, wrHit1, arHit0, arHit1;

   function automatic logic regHit(input logic [31:0] addr, input logic [31:0] offs);
      regHit = (addr >> 2) == ((`TGC_BASE_ADDR + offs) >> 2);
   endfunction

   function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      mergeStrb = res;
   endfunction

   // Bank placed at base zero of the engine space
   assign wrHit0 = regHit(awAddr_q, `TGC_CFG0_OFFS);
   assign wrHit1 = regHit(awAddr_q, `TGC_CFG1_OFFS);
   assign arHit0 = regHit(axiReq.araddr, `TGC_CFG0_OFFS);
   assign arHit1 = regHit(axiReq.araddr, `TGC_CFG1_OFFS);
   assign wrFire = ce && awHeld_q && wHeld_q && !bvalid_q;
   assign arFire = ce && arready_q && axiReq.arvalid;

   assign axiRsp.awready = awready_q;
   assign axiRsp.wready = wready_q;
   assign axiRsp.bvalid = bvalid_q;
   assign axiRsp.bresp = bresp_q;
   assign axiRsp.arready = arready_q;
   assign axiRsp.rvalid = rvalid_q;
   assign axiRsp.rdata = rdata_q;
   assign axiRsp.rresp = rresp_q;

   // Write address channel; ready drops until the response is taken
   always_ff @(posedge mclk) begin
      if (rst) begin
         awready_q <= 1'b1;
         awHeld_q <= 1'b0;
         awAddr_q <= 32'h0;
      end else if (ce) begin
         if (awready_q && axiReq.awvalid) begin
            awready_q <= 1'b0;
            awHeld_q <= 1'b1;
            awAddr_q <= axiReq.awaddr;
         end else if (wrFire) begin
            awHeld_q <= 1'b0;
         end else if (bvalid_q && axiReq.bready) begin
            awready_q <= 1'b1;
         end
      end
   end

   // Write data channel
   always_ff @(posedge mclk) begin
      if (rst) begin
         wready_q <= 1'b1;
         wHeld_q <= 1'b0;
         wData_q <= 32'h0;
         wStrb_q <= 4'h0;
      end else if (ce) begin
         if (wready_q && axiReq.wvalid) begin
            wready_q <= 1'b0;
            wHeld_q <= 1'b1;
            wData_q <= axiReq.wdata;
            wStrb_q <= axiReq.wstrb;
         end else if (wrFire) begin
            wHeld_q <= 1'b0;
         end else if (bvalid_q && axiReq.bready) begin
            wready_q <= 1'b1;
         end
      end
   end

   // Write response; unmapped addresses answer with an error
   always_ff @(posedge mclk) begin
      if (rst) begin
         bvalid_q <= 1'b0;
         bresp_q <= tgc_pkg::TGC_RESP_OKAY;
      end else if (ce) begin
         if (wrFire) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wrHit0 || wrHit1) ? tgc_pkg::TGC_RESP_OKAY : tgc_pkg::TGC_RESP_SLVERR;
         end else if (bvalid_q && axiReq.bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Register storage; reserved bits are not kept and read as zero
   always_ff @(posedge mclk) begin
      if (rst) begin
         cfg0_q <= tgc_pkg::tgc_cfg0_t'(`TGC_CFG0_RESET);
         cfg1_q <= `TGC_CFG1_RESET;
      end else if (wrFire) begin
         if (wrHit0) begin
            cfg0_q <= tgc_pkg::tgc_cfg0_t'(mergeStrb(cfg0_q, wData_q, wStrb_q)
                      & `TGC_CFG0_RW_MASK);
         end
         if (wrHit1) begin
            cfg1_q <= mergeStrb(cfg1_q, wData_q, wStrb_q);
         end
      end
   end

   // Read channel; data captured with the address
   always_ff @(posedge mclk) begin
      if (rst) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= tgc_pkg::TGC_RESP_OKAY;
      end else if (ce) begin
         if (arFire) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= (arHit0 || arHit1) ? tgc_pkg::TGC_RESP_OKAY : tgc_pkg::TGC_RESP_SLVERR;
            if (arHit0) begin
               rdata_q <= 32'(cfg0_q);
            end else if (arHit1) begin
               rdata_q <= cfg1_q;
            end else begin
               rdata_q <= 32'h0;
            end
         end else if (rvalid_q && axiReq.rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // Packet filter and queue arbitration
   always_ff @(posedge mclk) begin
      if (rst) begin
         rxPktDrop_q <= 1'b0;
         rxFifoFirst_q <= 1'b0;
      end else if (ce) begin
         rxPktDrop_q <= rxPktValid && rxPktSumBad && cfg0_q.dropBadIpSum;
         rxFifoFirst_q <= xcBundlesPresent
            && (32'(rxFifoLevel) > 32'(cfg0_q.rxFifoPrioLvl));
      end
   end

   // Framing, MAC and port mode; out-of-range trailer clamps, readback untouched
   always_ff @(posedge mclk) begin
      if (rst) begin
         trailerLen_q <= 4'h0;
         trailerPresent_q <= 1'b0;
         macMode_q <= tgc_pkg::TGC_MAC_MII;
         clkRecEnable_q <= 1'b0;
         highSpeedMode_q <= 1'b0;
         portEnable_q <= '1;
         generalConfigOne_q <= `TGC_CFG1_RESET;
      end else if (ce) begin
         trailerLen_q <= (cfg0_q.trailerLen > `TGC_TRAILER_MAX) ?
                         `TGC_TRAILER_MAX : cfg0_q.trailerLen;
         trailerPresent_q <= cfg0_q.trailerLen != 4'h0;
         macMode_q <= cfg0_q.macMode;
         clkRecEnable_q <= cfg0_q.clkRecEnable;
         highSpeedMode_q <= cfg0_q.highSpeed;
         portEnable_q <= cfg0_q.highSpeed ? PORT1_ONLY : '1;
         generalConfigOne_q <= cfg1_q;
      end
   end

   // DRAM controller setup; its reset is held until software releases it
   always_ff @(posedge mclk) begin
      if (rst) begin
         dramSize128_q <= 1'b0;
         dramClockSelect_q <= 2'h0;
         dramColBits_q <= `TGC_COL_BASE_BITS;
         dramCasLatency_q <= 2'h2;
         dramRstN_q <= 1'b0;
      end else if (ce) begin
         dramSize128_q <= cfg0_q.memSize;
         dramClockSelect_q <= cfg0_q.dramClockSelect;
         dramColBits_q <= `TGC_COL_BASE_BITS + 4'(cfg0_q.colWidth);
         dramCasLatency_q <= cfg0_q.casLatency;
         dramRstN_q <= cfg0_q.dramRstN;
      end
   end

   tgc_tick_gen #(
      .FINE_CYCLES(FINE_CYCLES),
      .COARSE_CYCLES(COARSE_CYCLES)
   ) tickGen (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .coarse(cfg0_q.maintenanceTickSelect),
      .tick_q(maintenanceTick_q)
   );

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   dropBadPkt_a: assert property (
      (ce && rxPktValid && rxPktSumBad && cfg0_q.dropBadIpSum) |=> rxPktDrop_q)
      else $error("bad checksum packet not dropped");
   keepPkt_a: assert property (
      (ce && !(rxPktSumBad && cfg0_q.dropBadIpSum)) |=> !rxPktDrop_q)
      else $error("packet dropped without cause");
   trailerRange_a: assert property (
      trailerLen_q <= `TGC_TRAILER_MAX && (trailerPresent_q == (trailerLen_q != 4'h0)))
      else $error("trailer length out of range");
   clkRecWrite_a: assert property (
      (wrFire && wrHit0 && wStrb_q[3] ##1 ce) |=>
      clkRecEnable_q == $past(wData_q[`TGC_CLKREC_POS], 2))
      else $error("clock recovery enable not applied");
   fifoPrio_a: assert property (
      (ce && !xcBundlesPresent) |=> !rxFifoFirst_q)
      else $error("fifo priority without cross-connect");
   macMode_a: assert property (
      ce |=> macMode_q == $past(cfg0_q.macMode))
      else $error("mac mode mismatch");
   portMode_a: assert property (
      (ce && cfg0_q.highSpeed) |=> portEnable_q == PORT1_ONLY && highSpeedMode_q)
      else $error("high speed port enables wrong");
   dramGeom_a: assert property (
      ce |=> dramColBits_q == `TGC_COL_BASE_BITS + 4'($past(cfg0_q.colWidth))
      && dramSize128_q == $past(cfg0_q.memSize))
      else $error("dram geometry wrong");
   dramCas_a: assert property (
      ce |=> dramCasLatency_q == $past(cfg0_q.casLatency)
      && dramClockSelect_q == $past(cfg0_q.dramClockSelect))
      else $error("dram timing wrong");
   dramRst_a: assert property (
      (ce && !cfg0_q.dramRstN) |=> !dramRstN_q)
      else $error("dram reset released early");
   writeResp_a: assert property (
      wrFire |=> bvalid_q && bresp_q == ($past(wrHit0 || wrHit1) ?
      tgc_pkg::TGC_RESP_OKAY : tgc_pkg::TGC_RESP_SLVERR))
      else $error("write response wrong");
   readBack_a: assert property (
      (arFire && arHit0) |=> rvalid_q && rdata_q == 32'($past(cfg0_q)))
      else $error("readback differs from register");
   readBackOne_a: assert property (
      (arFire && arHit1) |=> rvalid_q && rdata_q == $past(cfg1_q))
      else $error("second word readback wrong");
   readErr_a: assert property (
      (arFire && !(arHit0 || arHit1)) |=>
      rresp_q == tgc_pkg::TGC_RESP_SLVERR && rdata_q == 32'h0)
      else $error("unmapped read not refused");
   // Reserved bits are never stored, so software always sees them as zero
   rsvdZero_a: assert property (
      cfg0_q.rsvd13 == 2'h0 && cfg0_q.rsvd9 == 2'h0)
      else $error("reserved bits stored");
   trailerClamp_a: assert property (
      ce |=> trailerLen_q == (($past(cfg0_q.trailerLen) > `TGC_TRAILER_MAX) ?
      `TGC_TRAILER_MAX : $past(cfg0_q.trailerLen)))
      else $error("trailer clamp wrong");
   clkRecOff_a: assert property (
      (ce && !cfg0_q.clkRecEnable) |=> !clkRecEnable_q)
      else $error("clock recovery left running");
   cfgFreeze_a: assert property (
      !ce |=> $stable(cfg0_q) && $stable(cfg1_q))
      else $error("registers moved while frozen");

   cfgWrite_c: cover property (wrFire && wrHit0);
   cfgRead_c: cover property (arFire && arHit1);
   pktDrop_c: cover property (rxPktDrop_q);
   dramRelease_c: cover property (!dramRstN_q ##1 dramRstN_q);
   readErr_c: cover property (arFire && !(arHit0 || arHit1));
endmodule
`default_nettype wire

// ===== common/tgc_regs.svh
// Offsets, reset values and timing constants of the general configuration bank
`ifndef TGC_REGS_SVH
`define TGC_REGS_SVH

// Register space
`define TGC_BASE_ADDR 32'h0000_0000
`define TGC_CFG0_OFFS 32'h0000_0000
`define TGC_CFG1_OFFS 32'h0000_0004

// Reset values and writable bits
`define TGC_CFG0_RESET 32'h0100_0404
`define TGC_CFG1_RESET 32'h0000_0000
`define TGC_CFG0_RW_MASK 32'hffff_ccff

// Field positions in the first register
`define TGC_DROP_POS 31
`define TGC_CLKREC_POS 26
`define TGC_DRAMRST_POS 0

// Field limits
`define TGC_TRAILER_MAX 4'hc
`define TGC_COL_BASE_BITS 4'h8

// Timing
`define TGC_CLK_PERIOD_NS 5
`define TGC_TICK_FINE_NS 1000
`define TGC_TICK_COARSE_NS 100000
`define TGC_TICK_FINE_CYC (`TGC_TICK_FINE_NS / `TGC_CLK_PERIOD_NS)
`define TGC_TICK_COARSE_CYC (`TGC_TICK_COARSE_NS / `TGC_CLK_PERIOD_NS)

`endif

// ===== common/tgc_pkg.sv
// Types shared by the general configuration bank
`default_nettype none
package tgc_pkg;

   typedef enum logic [1:0] {
      TGC_MAC_MII = 2'h0,
      TGC_MAC_RMII = 2'h1,
      TGC_MAC_RSVD = 2'h2,
      TGC_MAC_SSMII = 2'h3
   } tgc_mac_mode_t;

   typedef enum logic [1:0] {
      TGC_RESP_OKAY = 2'h0,
      TGC_RESP_SLVERR = 2'h2
   } tgc_resp_t;

   typedef struct packed {
      logic dropBadIpSum;
      logic [3:0] trailerLen;
      logic clkRecEnable;
      logic [9:0] rxFifoPrioLvl;
      tgc_mac_mode_t macMode;
      logic [1:0] rsvd13;
      logic highSpeed;
      logic maintenanceTickSelect;
      logic [1:0] rsvd9;
      logic memSize;
      logic [1:0] dramClockSelect;
      logic [1:0] colWidth;
      logic [1:0] casLatency;
      logic dramRstN;
   } tgc_cfg0_t;

   typedef struct packed {
      logic awvalid;
      logic [31:0] awaddr;
      logic [2:0] awprot;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [31:0] araddr;
      logic [2:0] arprot;
      logic rready;
   } tgc_axil_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      tgc_resp_t bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      tgc_resp_t rresp;
   } tgc_axil_rsp_t;

endpackage
`default_nettype wire

// ===== design/tgc_tick_gen.sv
// Maintenance timestamp tick generator, fine or coarse period
`default_nettype none
`include "tgc_regs.svh"
module tgc_tick_gen #(
   parameter int FINE_CYCLES = `TGC_TICK_FINE_CYC,
   parameter int COARSE_CYCLES = `TGC_TICK_COARSE_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Period select and tick
   input wire logic coarse,
   output logic tick_q
);
   localparam int CNT_W = $clog2(COARSE_CYCLES + 1);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] last;
   logic sel_q;

   assign last = coarse ? CNT_W'(COARSE_CYCLES - 1) : CNT_W'(FINE_CYCLES - 1);

   // Period change restarts the count so no short tick leaks out
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
         sel_q <= 1'b1;
      end else if (ce) begin
         sel_q <= coarse;
         if (sel_q != coarse) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
         end else if (cnt_q == last) begin
            cnt_q <= '0;
            tick_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 1'b1;
            tick_q <= 1'b0;
         end
      end
   end

   // Helper: clock-enabled cycles since the last tick
   logic [31:0] since_q;
   always_ff @(posedge mclk) begin
      if (rst) begin
         since_q <= 32'h0;
      end else if (ce) begin
         if (sel_q != coarse) begin
            since_q <= 32'h0;
         end else begin
            since_q <= tick_q ? 32'h1 : since_q + 32'h1;
         end
      end
   end

   tickPeriod_a: assert property (@(posedge mclk) disable iff (rst)
      (ce && tick_q && since_q > 32'h1 && sel_q == coarse) |->
      since_q == 32'(coarse ? COARSE_CYCLES : FINE_CYCLES))
      else $error("tick period wrong");
endmodule
`default_nettype wire

// ===== dv/tgc_general_config_tb.sv
// Self-checking bench of the general configuration bank
`default_nettype none
`include "tgc_regs.svh"
module tgc_general_config_tb;
   timeunit 1ns;
   timeprecision 100ps;

   // Short tick periods keep the run brief
   localparam int FINE = 4;
   localparam int COARSE = 40;
   localparam int LIMIT = 20000;

   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   tgc_pkg::tgc_axil_req_t axiReq = '0;
   tgc_pkg::tgc_axil_rsp_t axiRsp;
   logic rxPktValid = 1'b0;
   logic rxPktSumBad = 1'b0;
   logic xcBundlesPresent = 1'b0;
   logic [9:0] rxFifoLevel = 10'h000;
   logic pktDrop;
   logic fifoFirst;
   logic [3:0] trailerLen;
   logic trailerPresent;
   tgc_pkg::tgc_mac_mode_t macMode;
   logic clkRecEnable;
   logic highSpeedMode;
   logic [7:0] portEnable;
   logic maintTick;
   logic dramSize128;
   logic [1:0] dramClockSelect;
   logic [3:0] dramColBits;
   logic [1:0] dramCasLatency;
   logic dramRstN;
   logic [31:0] cfgOne;
   int errors = 0;
   int checked = 0;
   int cycles = 0;

   always #2.5 mclk = ~mclk;

   tgc_general_config #(.NUM_PORTS(8), .LVL_W(10), .FINE_CYCLES(FINE), .COARSE_CYCLES(COARSE))
   dut_u (
      .mclk(mclk), .rst(rst), .ce(ce), .axiReq(axiReq), .axiRsp(axiRsp),
      .rxPktValid(rxPktValid), .rxPktSumBad(rxPktSumBad), .rxPktDrop_q(pktDrop),
      .xcBundlesPresent(xcBundlesPresent), .rxFifoLevel(rxFifoLevel),
      .rxFifoFirst_q(fifoFirst), .trailerLen_q(trailerLen),
      .trailerPresent_q(trailerPresent), .macMode_q(macMode),
      .clkRecEnable_q(clkRecEnable), .highSpeedMode_q(highSpeedMode),
      .portEnable_q(portEnable), .maintenanceTick_q(maintTick),
      .dramSize128_q(dramSize128), .dramClockSelect_q(dramClockSelect),
      .dramColBits_q(dramColBits), .dramCasLatency_q(dramCasLatency),
      .dramRstN_q(dramRstN), .generalConfigOne_q(cfgOne)
   );

   task print_verdict;
      if (errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // A hang counts as a mismatch
   always @(posedge mclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         errors++;
         print_verdict;
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Bench stays clear of the clock recovery region while that block is off
   task guardAddr(input logic [31:0] a);
      if (a[31:15] == 17'h9 && clkRecEnable !== 1'b1) begin
         errors++;
         $display("Error at %0t: clock recovery region accessed while off", $time);
      end
   endtask

   // Handshakes read 1 ns after an edge, which is what the next edge samples
   task axiWrite(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                 output tgc_pkg::tgc_resp_t r);
      bit awDone;
      bit wDone;
      bit bDone;
      bit awTake;
      bit wTake;
      awDone = 0;
      wDone = 0;
      bDone = 0;
      guardAddr(a);
      @(posedge mclk);
      axiReq.awvalid <= 1'b1;
      axiReq.awaddr <= a;
      axiReq.wvalid <= 1'b1;
      axiReq.wdata <= d;
      axiReq.wstrb <= s;
      axiReq.bready <= 1'b1;
      while (!bDone) begin
         #1;
         awTake = !awDone && axiRsp.awready === 1'b1;
         wTake = !wDone && axiRsp.wready === 1'b1;
         bDone = axiRsp.bvalid === 1'b1;
         r = axiRsp.bresp;
         @(posedge mclk);
         if (awTake) begin
            awDone = 1;
            axiReq.awvalid <= 1'b0;
         end
         if (wTake) begin
            wDone = 1;
            axiReq.wvalid <= 1'b0;
         end
      end
      axiReq.bready <= 1'b0;
   endtask

   task axiRead(input logic [31:0] a, output logic [31:0] d, output tgc_pkg::tgc_resp_t r);
      bit arDone;
      bit arTake;
      bit rDone;
      arDone = 0;
      rDone = 0;
      guardAddr(a);
      @(posedge mclk);
      axiReq.arvalid <= 1'b1;
      axiReq.araddr <= a;
      axiReq.rready <= 1'b1;
      while (!rDone) begin
         #1;
         arTake = !arDone && axiRsp.arready === 1'b1;
         rDone = axiRsp.rvalid === 1'b1;
         d = axiRsp.rdata;
         r = axiRsp.rresp;
         @(posedge mclk);
         if (arTake) begin
            arDone = 1;
            axiReq.arvalid <= 1'b0;
         end
      end
      axiReq.rready <= 1'b0;
   endtask

   task pkt(input logic bad, input logic exp);
      @(posedge mclk);
      rxPktValid <= 1'b1;
      rxPktSumBad <= bad;
      @(posedge mclk);
      rxPktValid <= 1'b0;
      #1 check(pktDrop, exp);
   endtask

   task arb(input logic xc, input logic [9:0] lvl, input logic exp);
      @(posedge mclk);
      xcBundlesPresent <= xc;
      rxFifoLevel <= lvl;
      @(posedge mclk);
      #1 check(fifoFirst, exp);
   endtask

   // Edges from one tick to the next
   task tickPeriod(output int p);
      do begin
         @(posedge mclk);
         #1;
      end while (maintTick !== 1'b1);
      p = 0;
      do begin
         @(posedge mclk);
         #1;
         p++;
      end while (maintTick !== 1'b1);
   endtask

   // Field codes follow the loop index; reserved bits kept at zero
   function automatic logic [31:0] mkWord(input logic [1:0] c);
      logic [3:0] tl;
      logic [9:0] lvl;
      tl = 4'(4 * c + 1);
      lvl = 10'(c * 341);
      return {c[0], tl, c[0], lvl, c, 2'b00, c[1], c[0], 2'b00, c[1], c, c, c, c[0]};
   endfunction

   initial begin
      logic [31:0] d;
      logic [31:0] w;
      logic [1:0] c;
      tgc_pkg::tgc_resp_t r;
      int p;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      axiRead(32'h0, d, r);
      check(d, 32'h0100_0404);
      check(d[25:16], 10'h100);
      check(d[10], 1'b1);
      check(d[2:1], 2'h2);
      check(d[0], 1'b0);
      check(dramRstN, 1'b0);
      check(clkRecEnable, 1'b0);
      check(portEnable, 8'hff);
      check(trailerPresent, 1'b0);
      check(dramColBits, 4'h8);
      check(dramCasLatency, 2'h2);
      tickPeriod(p);
      check(p, COARSE);
      arb(1'b1, 10'h101, 1'b1);
      arb(1'b1, 10'h100, 1'b0);
      axiRead(32'h4, d, r);
      check(d, 32'h0);
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         w = mkWord(c);
         axiWrite(32'h0, w, 4'hf, r);
         check(r, tgc_pkg::TGC_RESP_OKAY);
         axiRead(32'h0, d, r);
         check(d, w & 32'hffff_ccff);
         check(trailerLen, (c == 2'h3) ? 4'hc : 4'(4 * c + 1));
         check(trailerPresent, 1'b1);
         check(macMode, c);
         check(clkRecEnable, c[0]);
         check(highSpeedMode, c[1]);
         check(portEnable, c[1] ? 8'h01 : 8'hff);
         check(dramSize128, c[1]);
         check(dramClockSelect, c);
         check(dramColBits, 4'h8 + c);
         check(dramCasLatency, c);
         check(dramRstN, c[0]);
         pkt(1'b1, c[0]);
         pkt(1'b0, 1'b0);
         arb(1'b1, 10'(c * 341), 1'b0);
         arb(1'b1, 10'(c * 341 + 1), c != 2'h3);
         arb(1'b0, 10'h3ff, 1'b0);
         tickPeriod(p);
         check(p, c[0] ? COARSE : FINE);
      end
      // DRAM setup done, so the controller reset is pulsed low then high
      axiWrite(32'h0, w & 32'hffff_fffe, 4'hf, r);
      #1 check(dramRstN, 1'b0);
      axiWrite(32'h0, w, 4'hf, r);
      #1 check(dramRstN, 1'b1);
      // Unmapped place answers with an error and stores nothing
      axiWrite(32'h8, 32'hffff_ffff, 4'hf, r);
      check(r, tgc_pkg::TGC_RESP_SLVERR);
      axiRead(32'h8, d, r);
      check(r, tgc_pkg::TGC_RESP_SLVERR);
      check(d, 32'h0);
      axiWrite(32'h4, 32'ha5a5_5a5a, 4'hf, r);
      axiWrite(32'h4, 32'hffff_ffff, 4'h2, r);
      axiRead(32'h4, d, r);
      check(d, 32'ha5a5_ff5a);
      check(cfgOne, 32'ha5a5_ff5a);
      print_verdict;
   end
endmodule
`default_nettype wire
